// *** rtl/tos_trigger_out.sv ***
// Purpose: Trigger connector logic with per-output source selection.
// Assumes: All internal sources are on sys_clk_i; connector pins are not.
// Notes: Connector pins pass two flops; every internal source shares sys_clk_i.
//
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module tos_trigger_out
    import tos_pkg::*;
#(
    parameter int WIDTH_MAX = MIN_WIDTH_MAX_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] demod_phase_sign_i,
    input wire logic scope_trig_i,
    input wire logic scope_armed_i,
    input wire logic scope_active_i,
    input wire logic [3:0] generator_marker_i,
    input wire logic gen_enabled_i,
    input wire logic gen_waiting_i,
    input wire logic gen_fetching_i,
    input wire logic gen_playing_i,
    input wire logic [3:0] sequencer_trigger_i,
    input wire logic multi_unit_sync_clock_out_i,
    input wire logic multi_unit_sync_signal_out_i,
    input wire logic [1:0] trig_front_i,
    output logic [1:0] trig_front_o,
    output logic [1:0] trig_front_oe_o,
    input wire logic [1:0] trig_back_i,
    output logic [1:0] trig_back_o,
    output logic [NUM_CH-1:0][4:0] delay_tap_o
);
    typedef struct packed {
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [NUM_CH-1:0][4:0] sel;
        logic [NUM_CH-1:0][WIDTH_W-1:0] width;
        logic [NUM_CH-1:0][4:0] delay;
        logic [1:0] drive;
        logic [3:0] in_s1;
        logic [3:0] in_s2;
        logic [1:0] phase_q;
        logic [NUM_CH-1:0] ev_q;
        logic [NUM_CH-1:0][WIDTH_W-1:0] cnt;
        logic [NUM_CH-1:0] trig;
    } tos_state_t;

    localparam logic [WIDTH_W-1:0] WIDTH_LIM = WIDTH_W'(WIDTH_MAX);

    tos_state_t st_reg;
    tos_state_t st_next;

    function automatic logic [31:0] tos_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction : tos_merge

    // Channel index of an address inside the per-channel area, or none.
    function automatic logic tos_ch_hit(input logic [7:0] addr, output logic [1:0] ch);
        ch = addr[5:4];
        return (addr < CH_STRIDE * 8'(NUM_CH)) && (addr[1:0] == 2'h0);
    endfunction : tos_ch_hit

    always_comb begin
        logic [1:0] ch;
        logic hit;
        logic [31:0] wv;
        logic [4:0] s;
        logic ev;
        logic stretch;
        logic lvl;
        logic phase_ev;
        ch = 2'h0;
        hit = 1'b0;
        wv = 32'h00000000;
        s = SEL_OFF;
        ev = 1'b0;
        stretch = 1'b0;
        lvl = 1'b0;
        phase_ev = 1'b0;
        st_next = st_reg;

        // Write side: address and data are taken in either order.
        if (s_axi_awvalid && s_axi_awready) begin
            st_next.aw_have = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_next.w_have = 1'b1;
            st_next.w_data = s_axi_wdata;
            st_next.w_strb = s_axi_wstrb;
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
            st_next.aw_have = 1'b0;
            st_next.w_have = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = RESP_DECERR;
            hit = tos_ch_hit(st_reg.aw_addr, ch);
            if (hit && st_reg.aw_addr[3:0] == OFS_SEL) begin
                // Only this channel's fields change; the others run on untouched.
                wv = tos_merge(32'(st_reg.sel[ch]), st_reg.w_data, st_reg.w_strb);
                st_next.sel[ch] = wv[4:0];
                st_next.bresp = RESP_OKAY;
            end else if (hit && st_reg.aw_addr[3:0] == OFS_WIDTH) begin
                wv = tos_merge(32'(st_reg.width[ch]), st_reg.w_data, st_reg.w_strb);
                st_next.width[ch] = (wv > 32'(WIDTH_LIM)) ? WIDTH_LIM : wv[WIDTH_W-1:0];
                st_next.bresp = RESP_OKAY;
            end else if (hit && st_reg.aw_addr[3:0] == OFS_DELAY) begin
                wv = tos_merge(32'(st_reg.delay[ch]), st_reg.w_data, st_reg.w_strb);
                // Codes past the top of the delay line saturate.
                st_next.delay[ch] = (wv > 32'(DELAY_MAX_CODE)) ? DELAY_MAX_CODE : wv[4:0];
                st_next.bresp = RESP_OKAY;
            end else if (st_reg.aw_addr == ADDR_DRIVE) begin
                wv = tos_merge(32'(st_reg.drive), st_reg.w_data, st_reg.w_strb);
                st_next.drive = wv[1:0];
                st_next.bresp = RESP_OKAY;
            end else if (st_reg.aw_addr == ADDR_STATUS) begin
                st_next.bresp = RESP_OKAY;
            end
        end

        // Read side: one outstanding read, answered the cycle after it is taken.
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = RESP_OKAY;
            st_next.rdata = 32'h00000000;
            if (tos_ch_hit(s_axi_araddr, ch) && s_axi_araddr[3:0] == OFS_SEL) begin
                st_next.rdata = 32'(st_reg.sel[ch]);
            end else if (tos_ch_hit(s_axi_araddr, ch) && s_axi_araddr[3:0] == OFS_WIDTH) begin
                st_next.rdata = 32'(st_reg.width[ch]);
            end else if (tos_ch_hit(s_axi_araddr, ch) && s_axi_araddr[3:0] == OFS_DELAY) begin
                st_next.rdata = 32'(st_reg.delay[ch]);
            end else if (s_axi_araddr == ADDR_DRIVE) begin
                st_next.rdata = 32'(st_reg.drive);
            end else if (s_axi_araddr == ADDR_STATUS) begin
                st_next.rdata[STAT_LOW_POS +: 4] = ~st_reg.in_s2;
                st_next.rdata[STAT_HIGH_POS +: 4] = st_reg.in_s2;
            end else begin
                st_next.rresp = RESP_DECERR;
            end
        end

        // Connector inputs come from another domain and pass two flops.
        st_next.in_s1 = {trig_back_i, trig_front_i};
        st_next.in_s2 = st_reg.in_s1;
        st_next.phase_q = {demod_phase_sign_i[DEMOD_EVEN], demod_phase_sign_i[DEMOD_ODD]};

        for (int c = 0; c < NUM_CH; c++) begin
            s = st_reg.sel[c];
            ev = 1'b0;
            stretch = 1'b0;
            lvl = 1'b0;
            // A sign change of the phase is a zero crossing.
            phase_ev = (c % 2 == 0) ?
                (demod_phase_sign_i[DEMOD_ODD] != st_reg.phase_q[0]) :
                (demod_phase_sign_i[DEMOD_EVEN] != st_reg.phase_q[1]);
            case (s)
                SEL_OSC: lvl = phase_ev;
                SEL_SC_TRIG, SEL_SC_NTRIG: begin
                    ev = scope_trig_i;
                    stretch = 1'b1;
                end
                SEL_SC_ARMED, SEL_SC_NARMED: begin
                    ev = scope_armed_i;
                    stretch = 1'b1;
                end
                SEL_SC_ACTIVE, SEL_SC_NACTIVE: begin
                    ev = scope_active_i;
                    stretch = 1'b1;
                end
                SEL_GEN_ACTIVE: begin
                    ev = gen_enabled_i;
                    stretch = 1'b1;
                end
                SEL_GEN_WAIT: lvl = gen_waiting_i;
                SEL_GEN_FETCH: lvl = gen_fetching_i;
                SEL_GEN_PLAY: lvl = gen_playing_i;
                SEL_SYNC_CLK: lvl = multi_unit_sync_clock_out_i;
                SEL_SYNC_SIG: lvl = multi_unit_sync_signal_out_i;
                default: begin
                    if (s[4:2] == SEL_MARKER0[4:2]) begin
                        lvl = generator_marker_i[s[1:0]];
                    end else if (s[4:2] == SEL_SEQ0[4:2]) begin
                        ev = sequencer_trigger_i[s[1:0]];
                        stretch = 1'b1;
                    end
                end
            endcase
            // The stretch counter loads on each rising event edge.
            st_next.ev_q[c] = ev;
            if (stretch && ev && !st_reg.ev_q[c]) begin
                st_next.cnt[c] = st_reg.width[c];
            end else if (st_reg.cnt[c] != WIDTH_RST) begin
                st_next.cnt[c] = st_reg.cnt[c] - WIDTH_W'(1);
            end
            if (!stretch) begin
                st_next.cnt[c] = WIDTH_RST;
            end
            if (stretch) begin
                lvl = ev || (st_reg.cnt[c] != WIDTH_RST);
                if (s == SEL_SC_NTRIG || s == SEL_SC_NARMED || s == SEL_SC_NACTIVE) begin
                    lvl = !lvl;
                end
            end
            st_next.trig[c] = (s == SEL_OFF) ? 1'b0 : lvl;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
            st_reg.sel <= {NUM_CH{SEL_RST}};
            st_reg.width <= {NUM_CH{WIDTH_RST}};
            st_reg.delay <= {NUM_CH{DELAY_RST}};
            st_reg.drive <= DRIVE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign s_axi_awready = !st_reg.aw_have;
    assign s_axi_wready = !st_reg.w_have;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = !st_reg.rvalid;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;
    // The output value is always present; the enable decides who owns the pin.
    assign trig_front_o = st_reg.trig[1:0];
    assign trig_front_oe_o = st_reg.drive;
    assign trig_back_o = st_reg.trig[3:2];
    assign delay_tap_o = st_reg.delay;

    off_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        st_reg.sel[0] == SEL_OFF |=> !st_reg.trig[0])
        else $error("Output active while its source is off.");
    phase_pulse_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        st_reg.sel[1] == SEL_OSC && demod_phase_sign_i[DEMOD_EVEN] != st_reg.phase_q[1]
        |=> st_reg.trig[1])
        else $error("Phase zero crossing gave no pulse.");
    inv_trig_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        st_reg.sel[1] == SEL_SC_NTRIG && scope_trig_i |=> !st_reg.trig[1])
        else $error("Inverted scope trigger left output high.");
    gen_active_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        st_reg.sel[2] == SEL_GEN_ACTIVE && gen_enabled_i |=> st_reg.trig[2])
        else $error("Generator enabled but output low.");
    min_width_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        st_reg.sel[0] == SEL_SC_TRIG && scope_trig_i && !st_reg.ev_q[0]
        && st_reg.width[0] >= 23'h000003
        |=> (st_reg.trig[0] || st_reg.sel[0] != SEL_SC_TRIG) [*3])
        else $error("Scope event shorter than minimum width.");
    delay_range_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        delay_tap_o[2] <= DELAY_MAX_CODE)
        else $error("Delay code beyond range.");
    sync_clk_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        st_reg.sel[2] == SEL_SYNC_CLK |=> st_reg.trig[2] == $past(multi_unit_sync_clock_out_i))
        else $error("Output does not follow sync clock.");
    in_low_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (!trig_back_i[0]) [*3] |-> !st_reg.in_s2[2])
        else $error("Low input not reported as low.");
    in_high_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (trig_front_i[1]) [*3] |-> st_reg.in_s2[1])
        else $error("High input not reported as high.");
    marker_route_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        st_reg.sel[1] == SEL_MARKER0 && generator_marker_i[0] |=> st_reg.trig[1])
        else $error("Marker level not routed to output.");
    sync_sig_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        st_reg.sel[3] == SEL_SYNC_SIG |=> st_reg.trig[3] == $past(multi_unit_sync_signal_out_i))
        else $error("Output does not follow sync signal.");
endmodule : tos_trigger_out

// *** common/tos_pkg.sv ***
// Purpose: Constants shared by the trigger output source selector.
// Assumes: 50 MHz system clock, 32-bit AXI4-Lite register access.
// Notes: Register layout repeats per trigger output channel.
package tos_pkg;
    localparam int NUM_CH = 4;
    localparam int CLK_MHZ = 50;
    // Longest programmable minimum pulse width, in microseconds.
    localparam int MIN_WIDTH_MAX_US = 149000;
    localparam int MIN_WIDTH_MAX_CYC = MIN_WIDTH_MAX_US * CLK_MHZ;
    localparam int WIDTH_W = 23;
    // Fine output delay range and step, in picoseconds.
    localparam int DELAY_MAX_PS = 2400;
    localparam int DELAY_STEP_PS = 78;
    localparam logic [4:0] DELAY_MAX_CODE = 5'(DELAY_MAX_PS / DELAY_STEP_PS);
    // Byte offsets: each channel owns a block of CH_STRIDE bytes.
    localparam logic [7:0] CH_STRIDE = 8'h10;
    localparam logic [3:0] OFS_SEL = 4'h0;
    localparam logic [3:0] OFS_WIDTH = 4'h4;
    localparam logic [3:0] OFS_DELAY = 4'h8;
    localparam logic [7:0] ADDR_DRIVE = 8'h40;
    localparam logic [7:0] ADDR_STATUS = 8'h44;
    // Status word: low flags in bits 3:0, high flags in bits 7:4.
    localparam int STAT_LOW_POS = 0;
    localparam int STAT_HIGH_POS = 4;
    localparam logic [4:0] SEL_RST = 5'h00;
    localparam logic [WIDTH_W-1:0] WIDTH_RST = 23'h000000;
    localparam logic [4:0] DELAY_RST = 5'h00;
    localparam logic [1:0] DRIVE_RST = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // Demodulator indices: DEMOD_ODD feeds the phase mode of even channels, DEMOD_EVEN that of odd channels.
    localparam int DEMOD_ODD = 3;
    localparam int DEMOD_EVEN = 7;
    localparam logic [4:0] SEL_OFF = 5'h00;
    localparam logic [4:0] SEL_OSC = 5'h01;
    localparam logic [4:0] SEL_SC_TRIG = 5'h02;
    localparam logic [4:0] SEL_SC_NTRIG = 5'h03;
    localparam logic [4:0] SEL_SC_ARMED = 5'h04;
    localparam logic [4:0] SEL_SC_NARMED = 5'h05;
    localparam logic [4:0] SEL_SC_ACTIVE = 5'h06;
    localparam logic [4:0] SEL_SC_NACTIVE = 5'h07;
    localparam logic [4:0] SEL_MARKER0 = 5'h08;
    localparam logic [4:0] SEL_GEN_ACTIVE = 5'h0C;
    localparam logic [4:0] SEL_GEN_WAIT = 5'h0D;
    localparam logic [4:0] SEL_GEN_FETCH = 5'h0E;
    localparam logic [4:0] SEL_GEN_PLAY = 5'h0F;
    localparam logic [4:0] SEL_SEQ0 = 5'h10;
    localparam logic [4:0] SEL_SYNC_CLK = 5'h14;
    localparam logic [4:0] SEL_SYNC_SIG = 5'h15;
endpackage : tos_pkg

// *** test/tos_ext_instr.sv ***
// Purpose: Model of the external instruments wired to the trigger connectors.
// Assumes: Front pins are shared with the device; rear inputs are driven only from outside.
// Notes: A front pin that nobody drives toggles every cycle, so it never reads as a level.
`timescale 1ns/1ps
module tos_ext_instr (
    input wire logic sys_clk_i,
    input wire logic [1:0] pin_out_i,
    input wire logic [1:0] pin_oe_i,
    input wire logic [1:0] ext_drive_i,
    input wire logic [3:0] ext_level_i,
    output logic [1:0] front_level_o,
    output logic [1:0] back_level_o
);
    logic float_reg = 1'h0;

    always @(posedge sys_clk_i) begin
        float_reg <= ~float_reg;
    end

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (pin_oe_i[i]) begin
                front_level_o[i] = pin_out_i[i];
            end else if (ext_drive_i[i]) begin
                front_level_o[i] = ext_level_i[i];
            end else begin
                front_level_o[i] = float_reg;
            end
        end
    end

    assign back_level_o = ext_level_i[3:2];
endmodule : tos_ext_instr

// *** test/testbench.sv ***
// Purpose: Self-checking bench for the trigger output source selector.
// Assumes: 50 MHz clock, registers reached over AXI4-Lite.
// Notes: The minimum width limit is shrunk so that the clamp can be reached quickly.
`timescale 1ns/1ps
module testbench;
    import tos_pkg::*;
    localparam int SIM_WIDTH_MAX = 64;
    typedef struct packed {logic [4:0] sel; logic [4:0] src_bit; logic inv;} tos_row_t;
    // Source bits: 0 trig, 1 armed, 2 active, 3-6 markers, 7-10 generator, 11-14 sequencer,
    // 15 sync clock, 16 sync signal.
    localparam tos_row_t ROWS [20] = '{
        '{SEL_SC_TRIG, 5'h00, 1'h0}, '{SEL_SC_NTRIG, 5'h00, 1'h1},
        '{SEL_SC_ARMED, 5'h01, 1'h0}, '{SEL_SC_NARMED, 5'h01, 1'h1},
        '{SEL_SC_ACTIVE, 5'h02, 1'h0}, '{SEL_SC_NACTIVE, 5'h02, 1'h1},
        '{SEL_MARKER0, 5'h03, 1'h0}, '{5'h09, 5'h04, 1'h0},
        '{5'h0A, 5'h05, 1'h0}, '{5'h0B, 5'h06, 1'h0},
        '{SEL_GEN_ACTIVE, 5'h07, 1'h0}, '{SEL_GEN_WAIT, 5'h08, 1'h0},
        '{SEL_GEN_FETCH, 5'h09, 1'h0}, '{SEL_GEN_PLAY, 5'h0A, 1'h0},
        '{SEL_SEQ0, 5'h0B, 1'h0}, '{5'h11, 5'h0C, 1'h0},
        '{5'h12, 5'h0D, 1'h0}, '{5'h13, 5'h0E, 1'h0},
        '{SEL_SYNC_CLK, 5'h0F, 1'h0}, '{SEL_SYNC_SIG, 5'h10, 1'h0}
    };
    logic sys_clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [7:0] phase = 8'h00;
    logic [16:0] src = 17'h00000;
    logic [1:0] front_in, front_out, front_oe, back_in, back_out;
    logic [1:0] ext_drive = 2'h0;
    logic [3:0] ext_level = 4'h0;
    logic [NUM_CH-1:0][4:0] taps;
    int num_errors = 0;
    int checked = 0;

    always #10 sys_clk_i = ~sys_clk_i;

    tos_trigger_out #(.WIDTH_MAX(SIM_WIDTH_MAX)) dut (
        .sys_clk_i, .rst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .demod_phase_sign_i(phase), .scope_trig_i(src[0]),
        .scope_armed_i(src[1]), .scope_active_i(src[2]), .generator_marker_i(src[6:3]),
        .gen_enabled_i(src[7]), .gen_waiting_i(src[8]), .gen_fetching_i(src[9]),
        .gen_playing_i(src[10]), .sequencer_trigger_i(src[14:11]),
        .multi_unit_sync_clock_out_i(src[15]), .multi_unit_sync_signal_out_i(src[16]),
        .trig_front_i(front_in), .trig_front_o(front_out), .trig_front_oe_o(front_oe),
        .trig_back_i(back_in), .trig_back_o(back_out), .delay_tap_o(taps));

    tos_ext_instr ext (.sys_clk_i(sys_clk_i), .pin_out_i(front_out),
        .pin_oe_i(front_oe), .ext_drive_i(ext_drive), .ext_level_i(ext_level),
        .front_level_o(front_in), .back_level_o(back_in));

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_word

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic aw_done;
        logic w_done;
        aw_done = 1'h0;
        w_done = 1'h0;
        @(posedge sys_clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(aw_done && w_done)) begin
            @(posedge sys_clk_i);
            if (!aw_done && s_axi_awready) begin
                aw_done = 1'h1;
                s_axi_awvalid <= 1'h0;
            end
            if (!w_done && s_axi_wready) begin
                w_done = 1'h1;
                s_axi_wvalid <= 1'h0;
            end
        end
        while (s_axi_bvalid !== 1'h1) @(posedge sys_clk_i);
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge sys_clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge sys_clk_i);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask : axi_rd

    task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] resp;
        axi_wr(a, d, resp);
        chk_word({30'h0, resp}, {30'h0, er}, "write response");
    endtask : wr_chk

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] resp;
        axi_rd(a, d, resp);
        chk_word(d, ed, "read data");
        chk_word({30'h0, resp}, {30'h0, er}, "read response");
    endtask : rd_chk

    function automatic logic out_of(input int c);
        return (c < 2) ? front_out[c] : back_out[c-2];
    endfunction : out_of

    function automatic logic [7:0] ch_addr(input int c, input logic [3:0] ofs);
        return CH_STRIDE * 8'(c) + {4'h0, ofs};
    endfunction : ch_addr

    // Each byte of the result counts the high cycles of one channel, channel 0 lowest.
    task automatic count_all(input int n, output logic [31:0] cnt);
        cnt = 32'h0;
        repeat (n) begin
            @(posedge sys_clk_i);
            for (int c = 0; c < NUM_CH; c++) begin
                if (out_of(c) === 1'h1) cnt[c*8+:8] = cnt[c*8+:8] + 8'h01;
            end
        end
    endtask : count_all

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask : end_test

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    // The whole sequence needs a few hundred cycles; this margin only catches a hang.
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        num_errors++;
        $display("Error at %0t: watchdog expired", $time);
        final_report();
    end

    initial begin
        logic [31:0] cnt;
        int c;
        repeat (8) @(posedge sys_clk_i);
        rst_i <= 1'h0;
        chk_word({26'h0, front_out, front_oe, back_out}, 32'h0, "pins after reset");
        for (c = 0; c < NUM_CH; c++) begin
            rd_chk(ch_addr(c, OFS_SEL), 32'(SEL_RST), RESP_OKAY);
            rd_chk(ch_addr(c, OFS_WIDTH), 32'(WIDTH_RST), RESP_OKAY);
            rd_chk(ch_addr(c, OFS_DELAY), 32'(DELAY_RST), RESP_OKAY);
        end
        rd_chk(ADDR_DRIVE, 32'(DRIVE_RST), RESP_OKAY);
        end_test("reset");
        foreach (ROWS[i]) begin
            c = i % NUM_CH;
            wr_chk(ch_addr(c, OFS_SEL), 32'(ROWS[i].sel), RESP_OKAY);
            repeat (4) @(posedge sys_clk_i);
            chk_word(32'(out_of(c)), 32'(ROWS[i].inv), "idle level");
            src[ROWS[i].src_bit] <= 1'h1;
            repeat (4) @(posedge sys_clk_i);
            chk_word(32'(out_of(c)), 32'(!ROWS[i].inv), "source level");
            src <= 17'h00000;
        end
        end_test("source table");
        wr_chk(ch_addr(0, OFS_SEL), 32'(SEL_OFF), RESP_OKAY);
        wr_chk(ch_addr(1, OFS_SEL), 32'(SEL_SC_TRIG), RESP_OKAY);
        wr_chk(ch_addr(2, OFS_SEL), 32'(SEL_MARKER0), RESP_OKAY);
        wr_chk(ch_addr(3, OFS_SEL), 32'(SEL_SEQ0), RESP_OKAY);
        src <= 17'h1FFFF;
        repeat (3) @(posedge sys_clk_i);
        count_all(10, cnt);
        chk_word(cnt, 32'h0A0A0A00, "off and neighbours");
        src <= 17'h00000;
        end_test("off");
        for (c = 0; c < 3; c++) wr_chk(ch_addr(c, OFS_SEL), 32'(SEL_OSC), RESP_OKAY);
        phase <= 8'h08;
        count_all(8, cnt);
        chk_word(cnt, 32'h00010001, "demod 4 rise");
        phase <= 8'h88;
        count_all(8, cnt);
        chk_word(cnt, 32'h00000100, "demod 8 rise");
        phase <= 8'h80;
        count_all(8, cnt);
        chk_word(cnt, 32'h00010001, "demod 4 fall");
        end_test("phase");
        wr_chk(ch_addr(0, OFS_SEL), 32'(SEL_SC_TRIG), RESP_OKAY);
        wr_chk(ch_addr(1, OFS_SEL), 32'(SEL_MARKER0), RESP_OKAY);
        wr_chk(ch_addr(2, OFS_SEL), 32'(SEL_SC_NTRIG), RESP_OKAY);
        wr_chk(ch_addr(3, OFS_SEL), 32'(SEL_GEN_ACTIVE), RESP_OKAY);
        wr_chk(ch_addr(0, OFS_WIDTH), 32'(SIM_WIDTH_MAX + 5), RESP_OKAY);
        rd_chk(ch_addr(0, OFS_WIDTH), 32'(SIM_WIDTH_MAX), RESP_OKAY);
        wr_chk(ch_addr(1, OFS_WIDTH), 32'h0000000A, RESP_OKAY);
        wr_chk(ch_addr(2, OFS_WIDTH), 32'h0000000A, RESP_OKAY);
        @(posedge sys_clk_i);
        src <= 17'h00089;
        @(posedge sys_clk_i);
        src <= 17'h00000;
        count_all(80, cnt);
        chk_word(cnt, 32'h01450141, "stretched widths");
        end_test("stretch");
        wr_chk(ch_addr(1, OFS_DELAY), 32'h0000001F, RESP_OKAY);
        wr_chk(ch_addr(2, OFS_DELAY), 32'h00000005, RESP_OKAY);
        rd_chk(ch_addr(1, OFS_DELAY), 32'(DELAY_MAX_CODE), RESP_OKAY);
        chk_word({12'h0, taps}, {12'h0, 5'h00, 5'h05, DELAY_MAX_CODE, 5'h00}, "taps");
        end_test("delay");
        wr_chk(ch_addr(0, OFS_SEL), 32'(SEL_SC_TRIG), RESP_OKAY);
        src <= 17'h00001;
        ext_drive <= 2'h2;
        ext_level <= 4'hA;
        wr_chk(ADDR_DRIVE, 32'h00000001, RESP_OKAY);
        repeat (6) @(posedge sys_clk_i);
        chk_word({28'h0, front_oe, front_out[0], front_in[0]}, 32'h7, "front drive");
        rd_chk(ADDR_STATUS, 32'h000000B4, RESP_OKAY);
        ext_drive <= 2'h3;
        ext_level <= 4'h6;
        wr_chk(ADDR_DRIVE, 32'h00000000, RESP_OKAY);
        repeat (6) @(posedge sys_clk_i);
        chk_word({30'h0, front_oe}, 32'h0, "front released");
        wr_chk(ADDR_STATUS, 32'h000000FF, RESP_OKAY);
        rd_chk(ADDR_STATUS, 32'h00000069, RESP_OKAY);
        end_test("pins");
        rd_chk(8'h4C, 32'h0, RESP_DECERR);
        wr_chk(8'h4C, 32'h0000FFFF, RESP_DECERR);
        rd_chk(8'h02, 32'h0, RESP_DECERR);
        rd_chk(8'h0C, 32'h0, RESP_DECERR);
        end_test("unmapped");
        @(posedge sys_clk_i);
        rst_i <= 1'h1;
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'h0;
        @(posedge sys_clk_i);
        chk_word({26'h0, front_out, front_oe, back_out}, 32'h0, "pins after reset");
        rd_chk(ch_addr(0, OFS_SEL), 32'(SEL_RST), RESP_OKAY);
        rd_chk(ch_addr(1, OFS_DELAY), 32'(DELAY_RST), RESP_OKAY);
        end_test("reset again");
        final_report();
    end
endmodule : testbench
